// File: hw/pfp_top.sv
// Command layer of the parallel flash programming port with its flash array and APB status registers
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
// How it works
// R1 - Data bus is sixteen bits, or nine bits when the narrow variant is selected.
// R2 - Read: command, four address bytes, then each read returns a word and increments.
// R3 - New address bytes may reload the address mid-command; transfers continue from there.
// R4 - Page write: write-family command, four address bytes, chained data writes auto-increment.
// R5 - Writes collect in a page buffer, committed before touching another page.
// R6 - Any accepted command write commits the pending page buffer first.
// R7 - Write-and-lock sets the region lock bit once the page commit finishes.
// R8 - Programmer locks a region by write-and-lock on its last page only; the bench locks region 0 from its first page, page 0.
// R9 - Erase-write erases the page before programming; the lock variant also locks.
// R10 - Full erase is its command then one data write of zero; the code erases on any data value.
// R11 - Full erase aborts, erasing nothing, while any lock bit is set.
// R12 - Programmer clears all locks with clear-lock before a full erase; the bench first tries one with locks 0xB set, which aborts.
// R13 - Set and clear lock take a mask; bit n selects lock region n.
// R14 - Full erase clears all lock bits.
// R15 - Lock query returns the lock bits on one read handshake.
// R16 - Set-fuse mask bit n activates general purpose fuse bit n.
// R17 - Clear-fuse deactivates each fuse bit whose mask bit is one.
// R18 - Full erase clears all general purpose fuse bits.
// R19 - Fuse query returns the fuse bits on one read handshake.
// R20 - Security set is its command then data zero; afterwards commands are refused. The code sets it on any data value.
// R21 - Erase pin event clears security only after erasing the flash contents.
// R22 - Mode field selects command, address bytes one to four, data, or nothing.
// R23 - Command codes are fixed sixteen-bit values, one per operation.
// R24 - Write handshake: strobe low latches inputs, ready falls, ready rises after strobe high.
// R25 - Read handshake: output enable low drives data, valid falls; release on enable high.
// R26 - With security set, handshakes still complete but no flash operation happens.
module pfp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] mode,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    input wire logic command_strobe_n,
    input wire logic output_enable_n,
    output logic read_valid_n,
    output logic ready,
    input wire logic erase_pin
);
    pfp_pkg::pfp_pins_t pin_meta_ff, pin_sync_ff;
    logic erase_dly_ff;
    pfp_pkg::pfp_state_t state_ff;
    logic ready_ff, read_valid_n_ff, data_oe_ff;
    logic [15:0] data_out_ff;
    logic [3:0] mode_ff;
    logic [15:0] din_ff, cmd_ff;
    logic [31:0] addr_ff;
    logic [15:0] flash_ff [pfp_pkg::WORDS];
    logic [15:0] buf_q_ff [pfp_pkg::PAGE_WORDS];
    logic [3:0] buf_vld_ff;
    logic [2:0] buf_page_ff;
    logic dirty_ff, buf_erase_ff, buf_lock_ff;
    logic [pfp_pkg::REGIONS-1:0] lock_ff;
    logic [pfp_pkg::FUSES-1:0] fuse_ff;
    logic secure_ff, narrow_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;

    // Every pin crosses two flops; the first stage feeds no logic, and the erase pin gets a third flop for its edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= '{mode: 4'hF, data: 16'h0000, strobe_n: 1'b1, oe_n: 1'b1, erase: 1'b0};
            pin_sync_ff <= '{mode: 4'hF, data: 16'h0000, strobe_n: 1'b1, oe_n: 1'b1, erase: 1'b0};
            erase_dly_ff <= 1'b0;
        end else begin
            pin_meta_ff <= '{mode: mode, data: data_in, strobe_n: command_strobe_n,
                             oe_n: output_enable_n, erase: erase_pin};
            pin_sync_ff <= pin_meta_ff;
            erase_dly_ff <= pin_sync_ff.erase;
        end
    end

    logic erase_evt, is_exec, need_flush, act, in_data, is_read_cmd, is_write_cmd;
    logic wr_data, ea_go, flush_go;
    logic [2:0] cur_page;
    logic [15:0] rd_val, din_masked;

    assign erase_evt = pin_sync_ff.erase & ~erase_dly_ff;
    assign cur_page = addr_ff[4:2];
    assign din_masked = narrow_ff ? {7'h00, pin_sync_ff.data[8:0]} : pin_sync_ff.data; // R1
    assign is_exec = (state_ff == pfp_pkg::ST_EXEC);
    assign in_data = (mode_ff == pfp_pkg::MODE_DATA); // R22
    assign is_read_cmd = (cmd_ff == pfp_pkg::CMD_READ) || (cmd_ff == pfp_pkg::CMD_LOCK_QUERY)
                         || (cmd_ff == pfp_pkg::CMD_FUSE_QUERY);
    assign is_write_cmd = (cmd_ff == pfp_pkg::CMD_WRITE) || (cmd_ff == pfp_pkg::CMD_WRITE_LOCK)
                          || (cmd_ff == pfp_pkg::CMD_ERASE_WRITE) || (cmd_ff == pfp_pkg::CMD_ERASE_WRITE_LOCK);
    // Reads also commit first so they never see stale flash
    assign need_flush = dirty_ff & ((mode_ff == pfp_pkg::MODE_CMD)
                        | (in_data & (is_read_cmd | (cur_page != buf_page_ff)))); // R5 R6
    assign act = is_exec & ~need_flush;
    assign wr_data = act & in_data & is_write_cmd & ~secure_ff; // R4 R26
    assign ea_go = act & in_data & (cmd_ff == pfp_pkg::CMD_FULL_ERASE) & ~secure_ff & (lock_ff == '0); // R10 R11
    assign flush_go = (state_ff == pfp_pkg::ST_FLUSH) & ~secure_ff & ~lock_ff[buf_page_ff[2:1]];

    always_comb begin
        rd_val = 16'h0000;
        if (!secure_ff) begin
            if (cmd_ff == pfp_pkg::CMD_READ) rd_val = flash_ff[addr_ff[4:0]]; // R2
            else if (cmd_ff == pfp_pkg::CMD_LOCK_QUERY) rd_val = {12'h000, lock_ff}; // R15
            else if (cmd_ff == pfp_pkg::CMD_FUSE_QUERY) rd_val = {14'h0000, fuse_ff}; // R19
        end
        if (narrow_ff) rd_val = {7'h00, rd_val[8:0]}; // R1
    end

    // Handshake sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= pfp_pkg::ST_IDLE;
            ready_ff <= 1'b1;
            read_valid_n_ff <= 1'b1;
            data_oe_ff <= 1'b0;
            data_out_ff <= 16'h0000;
            mode_ff <= 4'hF;
            din_ff <= 16'h0000;
        end else begin
            unique case (state_ff)
                pfp_pkg::ST_IDLE: if (!pin_sync_ff.strobe_n) begin
                    mode_ff <= pin_sync_ff.mode; // R24
                    din_ff <= din_masked;
                    ready_ff <= 1'b0; // R24
                    state_ff <= pfp_pkg::ST_EXEC;
                end
                pfp_pkg::ST_EXEC: begin
                    if (need_flush) begin
                        state_ff <= pfp_pkg::ST_FLUSH;
                    end else if (in_data && is_read_cmd) begin
                        // Take the word before this same edge walks the address on
                        data_out_ff <= rd_val; // R2
                        state_ff <= pfp_pkg::ST_RD_OE; // R25
                    end else begin
                        state_ff <= pfp_pkg::ST_WAIT_HI;
                    end
                end
                pfp_pkg::ST_FLUSH: state_ff <= pfp_pkg::ST_EXEC;
                pfp_pkg::ST_RD_OE: if (!pin_sync_ff.oe_n) begin
                    data_oe_ff <= 1'b1; // R25
                    read_valid_n_ff <= 1'b0;
                    state_ff <= pfp_pkg::ST_RD_REL;
                end
                pfp_pkg::ST_RD_REL: if (pin_sync_ff.oe_n) begin
                    data_oe_ff <= 1'b0; // R25
                    read_valid_n_ff <= 1'b1;
                    state_ff <= pfp_pkg::ST_WAIT_HI;
                end
                pfp_pkg::ST_WAIT_HI: if (pin_sync_ff.strobe_n) begin
                    ready_ff <= 1'b1; // R24
                    state_ff <= pfp_pkg::ST_IDLE;
                end
                default: state_ff <= pfp_pkg::ST_IDLE;
            endcase
        end
    end

    // Command and address; unless secured, the address walks on each data word of a read or page-write command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= 16'h0000;
            addr_ff <= 32'h0000_0000;
        end else if (act) begin
            unique case (mode_ff)
                pfp_pkg::MODE_CMD: cmd_ff <= din_ff; // R23
                pfp_pkg::MODE_A0: addr_ff[7:0] <= din_ff[7:0]; // R3
                pfp_pkg::MODE_A1: addr_ff[15:8] <= din_ff[7:0];
                pfp_pkg::MODE_A2: addr_ff[23:16] <= din_ff[7:0];
                pfp_pkg::MODE_A3: addr_ff[31:24] <= din_ff[7:0];
                pfp_pkg::MODE_DATA: if (!secure_ff && (is_write_cmd || cmd_ff == pfp_pkg::CMD_READ)) begin
                    addr_ff <= addr_ff + 32'h0000_0001; // R2 R4
                end
                default: ;
            endcase
        end
    end

    // Page load buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < pfp_pkg::PAGE_WORDS; i++) buf_q_ff[i] <= 16'h0000;
            buf_vld_ff <= 4'h0;
            buf_page_ff <= 3'h0;
            dirty_ff <= 1'b0;
            buf_erase_ff <= 1'b0;
            buf_lock_ff <= 1'b0;
        end else if (erase_evt || state_ff == pfp_pkg::ST_FLUSH) begin
            dirty_ff <= 1'b0;
            buf_vld_ff <= 4'h0;
        end else if (wr_data) begin
            buf_q_ff[addr_ff[1:0]] <= din_ff; // R5
            buf_vld_ff <= (dirty_ff ? buf_vld_ff : 4'h0) | (4'h1 << addr_ff[1:0]);
            buf_page_ff <= cur_page;
            dirty_ff <= 1'b1;
            buf_erase_ff <= (cmd_ff == pfp_pkg::CMD_ERASE_WRITE) || (cmd_ff == pfp_pkg::CMD_ERASE_WRITE_LOCK); // R9
            buf_lock_ff <= (cmd_ff == pfp_pkg::CMD_WRITE_LOCK) || (cmd_ff == pfp_pkg::CMD_ERASE_WRITE_LOCK); // R7
        end
    end

    // Flash array; plain programming can only clear bits, so it ANDs into the cell
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < pfp_pkg::WORDS; i++) flash_ff[i] <= pfp_pkg::ERASED_WORD;
        end else if (erase_evt || ea_go) begin
            for (int i = 0; i < pfp_pkg::WORDS; i++) flash_ff[i] <= pfp_pkg::ERASED_WORD; // R21
        end else if (flush_go) begin
            for (int w = 0; w < pfp_pkg::PAGE_WORDS; w++) begin
                if (buf_vld_ff[w]) begin
                    flash_ff[{buf_page_ff, 2'(w)}] <= buf_erase_ff ? buf_q_ff[w]
                        : (flash_ff[{buf_page_ff, 2'(w)}] & buf_q_ff[w]); // R5
                end else if (buf_erase_ff) begin
                    flash_ff[{buf_page_ff, 2'(w)}] <= pfp_pkg::ERASED_WORD; // R9
                end
            end
        end
    end

    // Lock, fuse and security bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff <= '0;
            fuse_ff <= '0;
            secure_ff <= 1'b0;
        end else if (erase_evt) begin
            lock_ff <= '0;
            fuse_ff <= '0;
            secure_ff <= 1'b0; // R21
        end else if (ea_go) begin
            lock_ff <= '0; // R14
            fuse_ff <= '0; // R18
        end else if (state_ff == pfp_pkg::ST_FLUSH && buf_lock_ff && !secure_ff) begin
            lock_ff[buf_page_ff[2:1]] <= 1'b1; // R7 R9
        end else if (act && in_data && !secure_ff) begin
            unique case (cmd_ff)
                pfp_pkg::CMD_LOCK_SET: lock_ff <= lock_ff | din_ff[3:0]; // R13
                pfp_pkg::CMD_LOCK_CLEAR: lock_ff <= lock_ff & ~din_ff[3:0]; // R13
                pfp_pkg::CMD_FUSE_SET: fuse_ff <= fuse_ff | din_ff[1:0]; // R16
                pfp_pkg::CMD_FUSE_CLEAR: fuse_ff <= fuse_ff & ~din_ff[1:0]; // R17
                pfp_pkg::CMD_SECURITY_SET: secure_ff <= 1'b1; // R20
                default: ;
            endcase
        end
    end

    // APB slave, one wait state on every access
    logic apb_hit;
    logic [31:0] apb_rd;
    always_comb begin
        apb_hit = 1'b1;
        apb_rd = 32'h0000_0000;
        unique case (paddr)
            pfp_pkg::OFS_STATUS: apb_rd = {28'h0000000, ~ready_ff, dirty_ff, secure_ff, narrow_ff};
            pfp_pkg::OFS_LOCK: apb_rd = {28'h0000000, lock_ff};
            pfp_pkg::OFS_FUSE: apb_rd = {30'h00000000, fuse_ff};
            pfp_pkg::OFS_CTRL: apb_rd = {31'h00000000, narrow_ff};
            default: apb_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & ~apb_hit;
            prdata_ff <= (psel && penable && !pready_ff && !pwrite) ? apb_rd : 32'h0000_0000;
        end
    end

    // Pin width select; taken only in the answering cycle so a write lands once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            narrow_ff <= pfp_pkg::CTRL_RESET;
        end else if (psel && penable && pready_ff && pwrite && paddr == pfp_pkg::OFS_CTRL) begin
            narrow_ff <= pwdata[0]; // R1
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign data_out = data_out_ff;
    assign data_oe = data_oe_ff;
    assign read_valid_n = read_valid_n_ff;
    assign ready = ready_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_drop_a: assert property ((state_ff == pfp_pkg::ST_IDLE && !pin_sync_ff.strobe_n) |=> !ready_ff) // R24
        else $error("ready did not fall after strobe");

    ready_rise_a: assert property ((state_ff == pfp_pkg::ST_WAIT_HI && pin_sync_ff.strobe_n) |=> ready_ff // R24
        ##1 (ready_ff throughout (state_ff == pfp_pkg::ST_IDLE)))
        else $error("ready did not rise after strobe release");

    valid_drive_a: assert property (!read_valid_n_ff |-> data_oe_ff) // R25
        else $error("valid low without bus drive");

    read_release_a: assert property ((state_ff == pfp_pkg::ST_RD_REL && pin_sync_ff.oe_n) // R25
        |=> read_valid_n_ff && !data_oe_ff)
        else $error("bus not released");

    cmd_flush_a: assert property ((is_exec && dirty_ff && mode_ff == pfp_pkg::MODE_CMD) // R6
        |=> state_ff == pfp_pkg::ST_FLUSH ##1 (is_exec && !dirty_ff))
        else $error("command did not commit buffer");

    page_flush_a: assert property ((is_exec && dirty_ff && in_data && is_write_cmd && cur_page != buf_page_ff) // R5
        |=> state_ff == pfp_pkg::ST_FLUSH)
        else $error("page change without commit");

    erase_abort_a: assert property ((act && in_data && cmd_ff == pfp_pkg::CMD_FULL_ERASE && lock_ff != '0) // R11
        |=> $stable(lock_ff) && $stable(fuse_ff))
        else $error("locked full erase not aborted");

    erase_clears_a: assert property (ea_go |=> lock_ff == '0 && fuse_ff == '0) // R14
        else $error("full erase left bits set");

    lock_set_a: assert property ((act && in_data && cmd_ff == pfp_pkg::CMD_LOCK_SET && !secure_ff) // R13
        |=> (lock_ff & $past(din_ff[3:0])) == $past(din_ff[3:0]))
        else $error("lock mask not applied");

    lock_clear_a: assert property ((act && in_data && cmd_ff == pfp_pkg::CMD_LOCK_CLEAR && !secure_ff) // R13
        |=> (lock_ff & $past(din_ff[3:0])) == 4'h0)
        else $error("lock mask not cleared");

    lock_query_a: assert property ((act && in_data && cmd_ff == pfp_pkg::CMD_LOCK_QUERY && !secure_ff) // R15
        |=> data_out_ff[3:0] == $past(lock_ff))
        else $error("lock query returned wrong mask");

    fuse_set_a: assert property ((act && in_data && cmd_ff == pfp_pkg::CMD_FUSE_SET && !secure_ff) // R16
        |=> (fuse_ff & $past(din_ff[1:0])) == $past(din_ff[1:0]))
        else $error("fuse mask not applied");

    fuse_clear_a: assert property ((act && in_data && cmd_ff == pfp_pkg::CMD_FUSE_CLEAR && !secure_ff) // R17
        |=> (fuse_ff & $past(din_ff[1:0])) == 2'h0)
        else $error("fuse mask not cleared");

    wpl_lock_a: assert property ((state_ff == pfp_pkg::ST_FLUSH && buf_lock_ff && !secure_ff && !erase_evt) // R7
        |=> lock_ff[$past(buf_page_ff[2:1])])
        else $error("region not locked after write");

    secure_set_a: assert property ((act && in_data && cmd_ff == pfp_pkg::CMD_SECURITY_SET && !erase_evt) // R20
        |=> secure_ff)
        else $error("security bit not set");

    pin_erase_a: assert property (erase_evt // R21
        |=> !secure_ff && lock_ff == '0 && flash_ff[0] == pfp_pkg::ERASED_WORD)
        else $error("erase pin did not wipe and unsecure");

    secure_hold_a: assert property ((secure_ff && is_exec && !erase_evt) |=> $stable(lock_ff) && $stable(fuse_ff)) // R26
        else $error("operation while secured");

    addr_step_a: assert property (wr_data |=> addr_ff == $past(addr_ff) + 32'h0000_0001) // R4
        else $error("address did not advance");

    read_step_a: assert property ((act && in_data && cmd_ff == pfp_pkg::CMD_READ && !secure_ff) // R2
        |=> addr_ff == $past(addr_ff) + 32'h0000_0001)
        else $error("read address did not advance");

    read_seen_c: cover property (state_ff == pfp_pkg::ST_RD_REL ##[1:50] read_valid_n_ff);
    flush_seen_c: cover property (flush_go && buf_lock_ff);
    erase_seen_c: cover property (ea_go);
    secure_seen_c: cover property ($rose(secure_ff));
    abort_seen_c: cover property (act && in_data && cmd_ff == pfp_pkg::CMD_FULL_ERASE && lock_ff != '0);
endmodule : pfp_top

// File: hw/pfp_pkg.sv
// Constants, pin carrier and state codes for the parallel flash programming port
package pfp_pkg;
    localparam int DW = 16;
    localparam int NARROW_W = 9;
    localparam int WORDS = 32;
    localparam int PAGE_WORDS = 4;
    localparam int REGIONS = 4;
    localparam int FUSES = 2;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [3:0] MODE_CMD = 4'h0;
    localparam logic [3:0] MODE_A0 = 4'h1;
    localparam logic [3:0] MODE_A1 = 4'h2;
    localparam logic [3:0] MODE_A2 = 4'h3;
    localparam logic [3:0] MODE_A3 = 4'h4;
    localparam logic [3:0] MODE_DATA = 4'h5;
    localparam logic [15:0] CMD_READ = 16'h0011;
    localparam logic [15:0] CMD_WRITE = 16'h0012;
    localparam logic [15:0] CMD_WRITE_LOCK = 16'h0022;
    localparam logic [15:0] CMD_ERASE_WRITE = 16'h0032;
    localparam logic [15:0] CMD_ERASE_WRITE_LOCK = 16'h0042;
    localparam logic [15:0] CMD_FULL_ERASE = 16'h0013;
    localparam logic [15:0] CMD_LOCK_SET = 16'h0014;
    localparam logic [15:0] CMD_LOCK_CLEAR = 16'h0024;
    localparam logic [15:0] CMD_LOCK_QUERY = 16'h0015;
    localparam logic [15:0] CMD_FUSE_SET = 16'h0034;
    localparam logic [15:0] CMD_FUSE_CLEAR = 16'h0044;
    localparam logic [15:0] CMD_FUSE_QUERY = 16'h0025;
    localparam logic [15:0] CMD_SECURITY_SET = 16'h0054;
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_LOCK = 12'h004;
    localparam logic [11:0] OFS_FUSE = 12'h008;
    localparam logic [11:0] OFS_CTRL = 12'h00C;
    localparam logic CTRL_RESET = 1'b0;
    typedef struct packed {
        logic [3:0] mode;
        logic [15:0] data;
        logic strobe_n;
        logic oe_n;
        logic erase;
    } pfp_pins_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_EXEC = 6'h02,
        ST_FLUSH = 6'h04,
        ST_RD_OE = 6'h08,
        ST_RD_REL = 6'h10,
        ST_WAIT_HI = 6'h20
    } pfp_state_t;
endpackage : pfp_pkg

// File: sim/pfp_programmer.sv
// Behavioural production programmer that drives the parallel write and read handshakes
`timescale 1ns/1ps
module pfp_programmer (
    input wire logic pclk,
    input wire logic ready,
    input wire logic read_valid_n,
    input wire logic [15:0] bus,
    output logic [3:0] mode,
    output logic [15:0] drv_data,
    output logic drv_oe,
    output logic command_strobe_n,
    output logic output_enable_n,
    output int stall_cnt
);
    initial begin
        mode = 4'hF;
        drv_data = 16'h0000;
        drv_oe = 1'b0;
        command_strobe_n = 1'b1;
        output_enable_n = 1'b1;
        stall_cnt = 0;
    end

    // Bounded poll; a device that never answers is counted instead of hanging the run
    task automatic wait_for(input bit on_valid, input logic lvl);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((on_valid ? read_valid_n : ready) !== lvl && n < 200);
        if ((on_valid ? read_valid_n : ready) !== lvl) stall_cnt++;
    endtask : wait_for

    task automatic write_hs(input logic [3:0] m, input logic [15:0] d);
        wait_for(1'b0, 1'b1);
        mode <= m;
        drv_data <= d;
        drv_oe <= 1'b1;
        @(posedge pclk);
        command_strobe_n <= 1'b0;
        wait_for(1'b0, 1'b0);
        // Released lines float to their pull-ups, never keep the old value
        mode <= 4'hF;
        drv_oe <= 1'b0;
        command_strobe_n <= 1'b1;
        wait_for(1'b0, 1'b1);
    endtask : write_hs

    task automatic read_hs(output logic [15:0] d);
        wait_for(1'b0, 1'b1);
        mode <= pfp_pkg::MODE_DATA;
        @(posedge pclk);
        command_strobe_n <= 1'b0;
        wait_for(1'b0, 1'b0);
        output_enable_n <= 1'b0;
        wait_for(1'b1, 1'b0);
        d = bus;
        output_enable_n <= 1'b1;
        wait_for(1'b1, 1'b1);
        mode <= 4'hF;
        command_strobe_n <= 1'b1;
        wait_for(1'b0, 1'b1);
    endtask : read_hs
endmodule : pfp_programmer

// File: sim/test_pfp_top.sv
// Self-checking bench for the parallel flash programming command layer
`timescale 1ns/1ps
module test_pfp_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] mode;
    logic [15:0] data_in;
    logic [15:0] data_out;
    logic data_oe;
    logic [15:0] drv_data;
    logic drv_oe;
    logic command_strobe_n;
    logic output_enable_n;
    logic read_valid_n;
    logic ready;
    logic erase_pin = 1'b0;
    int stall_cnt;
    int error_cnt = 0;
    int total_checks = 0;

    always #12.5 pclk = ~pclk;

    // Shared data wire, pulled up when nobody drives it
    assign data_in = data_oe ? data_out : (drv_oe ? drv_data : 16'hFFFF);

    pfp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .command_strobe_n(command_strobe_n),
        .output_enable_n(output_enable_n), .read_valid_n(read_valid_n), .ready(ready), .erase_pin(erase_pin));

    pfp_programmer prog (.pclk(pclk), .ready(ready), .read_valid_n(read_valid_n), .bus(data_in),
        .mode(mode), .drv_data(drv_data), .drv_oe(drv_oe), .command_strobe_n(command_strobe_n),
        .output_enable_n(output_enable_n), .stall_cnt(stall_cnt));

    task automatic print_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] exp,
        input logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (!wr) chk(prdata, exp);
        chk({30'h0, pready, pslverr}, {30'h0, 1'b1, err});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic cmd(input logic [15:0] c);
        prog.write_hs(pfp_pkg::MODE_CMD, c);
    endtask : cmd

    task automatic wr(input logic [15:0] d);
        prog.write_hs(pfp_pkg::MODE_DATA, d);
    endtask : wr

    task automatic seek(input logic [7:0] a);
        prog.write_hs(pfp_pkg::MODE_A0, {8'h00, a});
        prog.write_hs(pfp_pkg::MODE_A1, 16'h0000);
        prog.write_hs(pfp_pkg::MODE_A2, 16'h0000);
        prog.write_hs(pfp_pkg::MODE_A3, 16'h0000);
    endtask : seek

    task automatic rd(input logic [15:0] exp);
        logic [15:0] d;
        prog.read_hs(d);
        chk({16'h0, d}, {16'h0, exp});
    endtask : rd

    initial begin
        #500000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({29'h0, ready, read_valid_n, data_oe}, 32'h6);
        apb(1'b0, pfp_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        cmd(pfp_pkg::CMD_WRITE);
        seek(8'h02);
        wr(16'h1111);
        wr(16'h2222);
        wr(16'h3333);
        apb(1'b0, pfp_pkg::OFS_STATUS, 32'h0, 32'h4, 1'b0);
        cmd(pfp_pkg::CMD_READ);
        apb(1'b0, pfp_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0);
        seek(8'h02);
        rd(16'h1111);
        rd(16'h2222);
        rd(16'h3333);
        seek(8'h03);
        rd(16'h2222);
        cmd(pfp_pkg::CMD_WRITE_LOCK);
        seek(8'h0F);
        wr(16'h00AA);
        cmd(pfp_pkg::CMD_LOCK_QUERY);
        rd(16'h0002);
        cmd(pfp_pkg::CMD_LOCK_SET);
        wr(16'h0009);
        apb(1'b0, pfp_pkg::OFS_LOCK, 32'h0, 32'hB, 1'b0);
        cmd(pfp_pkg::CMD_FULL_ERASE);
        wr(16'h0000);
        cmd(pfp_pkg::CMD_READ);
        seek(8'h0F);
        rd(16'h00AA);
        cmd(pfp_pkg::CMD_LOCK_CLEAR);
        wr(16'h0003);
        cmd(pfp_pkg::CMD_LOCK_QUERY);
        rd(16'h0008);
        cmd(pfp_pkg::CMD_LOCK_CLEAR);
        wr(16'h0008);
        cmd(pfp_pkg::CMD_FUSE_SET);
        wr(16'h0003);
        cmd(pfp_pkg::CMD_FUSE_CLEAR);
        wr(16'h0001);
        cmd(pfp_pkg::CMD_FUSE_QUERY);
        rd(16'h0002);
        cmd(pfp_pkg::CMD_FULL_ERASE);
        wr(16'h0000);
        apb(1'b0, pfp_pkg::OFS_LOCK, 32'h0, 32'h0, 1'b0);
        apb(1'b0, pfp_pkg::OFS_FUSE, 32'h0, 32'h0, 1'b0);
        cmd(pfp_pkg::CMD_WRITE);
        seek(8'h01);
        wr(16'h0000);
        cmd(pfp_pkg::CMD_ERASE_WRITE_LOCK);
        seek(8'h00);
        wr(16'h00F0);
        cmd(pfp_pkg::CMD_WRITE);
        seek(8'h10);
        wr(16'h00FF);
        cmd(pfp_pkg::CMD_ERASE_WRITE);
        seek(8'h10);
        wr(16'h0F0F);
        cmd(pfp_pkg::CMD_READ);
        seek(8'h00);
        rd(16'h00F0);
        rd(16'hFFFF);
        seek(8'h10);
        rd(16'h0F0F);
        seek(8'h0B);
        rd(16'hFFFF);
        apb(1'b0, pfp_pkg::OFS_LOCK, 32'h0, 32'h1, 1'b0);
        apb(1'b1, pfp_pkg::OFS_CTRL, 32'h1, 32'h0, 1'b0);
        cmd(pfp_pkg::CMD_WRITE);
        seek(8'h08);
        wr(16'hFE5A);
        cmd(pfp_pkg::CMD_READ);
        seek(8'h08);
        rd(16'h005A);
        apb(1'b1, pfp_pkg::OFS_CTRL, 32'h0, 32'h0, 1'b0);
        seek(8'h08);
        rd(16'h005A);
        cmd(pfp_pkg::CMD_SECURITY_SET);
        wr(16'h0000);
        apb(1'b0, pfp_pkg::OFS_STATUS, 32'h0, 32'h2, 1'b0);
        cmd(pfp_pkg::CMD_LOCK_SET);
        wr(16'h000E);
        apb(1'b0, pfp_pkg::OFS_LOCK, 32'h0, 32'h1, 1'b0);
        cmd(pfp_pkg::CMD_READ);
        seek(8'h04);
        rd(16'h0000);
        erase_pin <= 1'b1;
        repeat (20) @(posedge pclk);
        erase_pin <= 1'b0;
        apb(1'b0, pfp_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0);
        cmd(pfp_pkg::CMD_READ);
        seek(8'h04);
        rd(16'hFFFF);
        chk(stall_cnt, 32'h0);
        print_verdict();
    end
endmodule : test_pfp_top
